// >>> rtl/strap_cfg_pkg.sv
// Package with constants and carrier types for the strap configuration block
package strap_cfg_pkg;
    // ****************************************
    // Timing and reset values
    // ****************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETTLE_TIME_NS = 100;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SETTLE_LAST = 3'(SETTLE_CYCLES - 1);
    localparam logic [6:0] ADDR_BASE = 7'h08;
    localparam int ADDR_BIT1 = 1;
    localparam int ADDR_BIT2 = 2;
    localparam int ADDR_BIT3 = 3;
    localparam logic MODE_SMBUS = 1'b0;
    localparam logic POL_ACTIVE_LOW = 1'b1;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0]
    {
        ST_SYNC = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_RUN = 2'b10
    } phase_t;

    typedef struct packed
    {
        logic serial_mode_select_n;
        logic power_control_polarity;
        logic slave_addr_bit2_strap;
        logic power_switching_disable_n;
        logic test_strap;
    } straps_t;

    typedef struct packed
    {
        logic superspeed_status_port2;
        logic superspeed_status_port1;
        logic upstream_highspeed_status;
        logic upstream_superspeed_status;
    } link_status_t;

    typedef struct packed
    {
        logic i2c_mode;
        logic smbus_mode;
        logic ganged;
        logic switching_enabled;
        logic test_mode;
        logic [6:0] slave_addr;
    } config_t;

    typedef struct packed
    {
        logic [1:0] scl_oe;
        logic [1:0] sda_oe;
        logic [1:0] scl_out;
        logic [1:0] sda_out;
    } serial_route_t;
endpackage

// >>> rtl/reset_strap_config_status.sv
// Reset-time strap capture, serial pin routing and shared status pins
`timescale 1ns/1ps
module reset_strap_config_status
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire strap_cfg_pkg::straps_t strap_in,
    output logic [3:0] strap_pin_out,
    output logic [3:0] strap_pin_oe,
    input wire strap_cfg_pkg::link_status_t link_status,
    input wire logic [1:0] port_power_request,
    output logic [1:0] port_power_control_out,
    input wire logic overcurrent_port1_n,
    input wire logic overcurrent_port2_n,
    output logic [1:0] port_overcurrent,
    output logic hub_overcurrent,
    output strap_cfg_pkg::config_t config_out,
    input wire strap_cfg_pkg::serial_route_t engine_serial,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe
);
    import strap_cfg_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed
    {
        phase_t phase;
        logic [2:0] count;
        straps_t sync1;
        straps_t sync2;
        logic [1:0] oc_sync1;
        logic [1:0] oc_sync2;
        straps_t latched;
        config_t cfg;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        logic [1:0] pwr;
        logic [1:0] oc_port;
        logic oc_hub;
        logic scl_o;
        logic scl_e;
        logic sda_o;
        logic sda_e;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        logic [1:0] oc_active;
        logic [1:0] req;
        logic sel;
        oc_active = 2'h0;
        req = 2'h0;
        sel = 1'b0;
        state_next = state_reg;
        state_next.sync1 = strap_in;
        state_next.sync2 = state_reg.sync1;
        state_next.oc_sync1 = {overcurrent_port2_n, overcurrent_port1_n};
        state_next.oc_sync2 = state_reg.oc_sync1;
        unique case (state_reg.phase)
            ST_SYNC:
            begin
                // Let the strap synchronisers settle before sampling
                state_next.count = state_reg.count + 3'h1;
                if (state_reg.count == SETTLE_LAST)
                begin
                    state_next.phase = ST_SAMPLE;
                end
            end
            ST_SAMPLE:
            begin
                // Every strap captured on the same edge
                state_next.latched = state_reg.sync2;
                state_next.cfg.i2c_mode = state_reg.sync2.serial_mode_select_n;
                state_next.cfg.smbus_mode =
                    (state_reg.sync2.serial_mode_select_n == MODE_SMBUS);
                state_next.cfg.ganged = state_reg.sync2.slave_addr_bit2_strap;
                state_next.cfg.switching_enabled =
                    ~state_reg.sync2.power_switching_disable_n;
                state_next.cfg.test_mode = state_reg.sync2.test_strap;
                state_next.cfg.slave_addr = ADDR_BASE;
                if (state_reg.sync2.serial_mode_select_n == MODE_SMBUS)
                begin
                    state_next.cfg.slave_addr[ADDR_BIT2] =
                        state_reg.sync2.slave_addr_bit2_strap;
                    state_next.cfg.slave_addr[ADDR_BIT1] =
                        state_reg.sync2.power_switching_disable_n;
                end
                state_next.cfg.slave_addr[ADDR_BIT3] = 1'b1;
                state_next.phase = ST_RUN;
            end
            ST_RUN:
            begin
                state_next.phase = ST_RUN;
            end
            default:
            begin
                state_next.phase = ST_SYNC;
            end
        endcase

        // ****************************************
        // Shared pins turn into status outputs once sampling is done
        // ****************************************
        if (state_reg.phase == ST_RUN)
        begin
            state_next.pin_oe = 4'hF;
            state_next.pin_out = {link_status.superspeed_status_port2,
                                  link_status.superspeed_status_port1,
                                  link_status.upstream_highspeed_status,
                                  link_status.upstream_superspeed_status};
        end
        else
        begin
            state_next.pin_oe = 4'h0;
            state_next.pin_out = 4'h0;
        end

        // ****************************************
        // Overcurrent decode
        // ****************************************
        oc_active = ~state_reg.oc_sync2;
        if (state_reg.phase == ST_RUN && state_reg.cfg.switching_enabled)
        begin
            if (state_reg.cfg.ganged)
            begin
                state_next.oc_hub = |oc_active;
                state_next.oc_port = 2'h0;
                req = (|port_power_request && !(|oc_active)) ? 2'h3 : 2'h0;
            end
            else
            begin
                state_next.oc_hub = 1'b0;
                state_next.oc_port = oc_active;
                req = port_power_request & ~oc_active;
            end
        end
        else
        begin
            state_next.oc_hub = 1'b0;
            state_next.oc_port = 2'h0;
        end
        state_next.pwr = (state_reg.latched.power_control_polarity == POL_ACTIVE_LOW) ?
                         ~req : req;

        // ****************************************
        // Serial pin routing
        // ****************************************
        sel = state_reg.cfg.smbus_mode ? 1'b1 : 1'b0;
        if (state_reg.phase == ST_RUN)
        begin
            state_next.scl_o = engine_serial.scl_out[sel];
            state_next.scl_e = engine_serial.scl_oe[sel];
            state_next.sda_o = engine_serial.sda_out[sel];
            state_next.sda_e = engine_serial.sda_oe[sel];
        end
        else
        begin
            state_next.scl_o = 1'b0;
            state_next.scl_e = 1'b0;
            state_next.sda_o = 1'b0;
            state_next.sda_e = 1'b0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign strap_pin_out = state_reg.pin_out;
    assign strap_pin_oe = state_reg.pin_oe;
    assign port_power_control_out = state_reg.pwr;
    assign port_overcurrent = state_reg.oc_port;
    assign hub_overcurrent = state_reg.oc_hub;
    assign config_out = state_reg.cfg;
    assign scl_out = state_reg.scl_o;
    assign scl_oe = state_reg.scl_e;
    assign sda_out = state_reg.sda_o;
    assign sda_oe = state_reg.sda_e;
endmodule // reset_strap_config_status

// >>> tb/strap_board.sv
// Board straps and status wiring model
`timescale 1ns/1ps
module strap_board
(
    input wire strap_cfg_pkg::straps_t board_cfg,
    input wire logic [3:0] drv,
    input wire logic [3:0] drv_oe,
    output strap_cfg_pkg::straps_t level
);
    // Resistor level until the device drives the pin
    always_comb
    begin
        level = board_cfg;
        for (int i = 0; i < 4; i++)
        begin
            if (drv_oe[i])
                level[i + 1] = drv[i];
        end
    end
endmodule // strap_board

// >>> tb/strap_cfg_chk.sv
// Port checker for the strap block
`timescale 1ns/1ps
module strap_cfg_chk
(
    input wire logic core_clk,
    input wire logic reset_n,
    input logic [3:0] strap_pin_out,
    input logic [3:0] strap_pin_oe,
    input wire strap_cfg_pkg::link_status_t link_status,
    input wire logic overcurrent_port1_n,
    input wire logic overcurrent_port2_n,
    input logic [1:0] port_overcurrent,
    input logic hub_overcurrent,
    input strap_cfg_pkg::config_t config_out,
    input wire strap_cfg_pkg::serial_route_t engine_serial,
    input logic scl_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence settle_s; !strap_pin_oe[0] [*6]; endsequence
    sequence live_s; strap_pin_oe == 4'hF; endsequence
    wake_order_a: assert property ($rose(reset_n) |-> settle_s ##[1:3] live_s)
        else $error("status pins early or late");
    mode_pair_a: assert property (live_s |-> config_out.i2c_mode != config_out.smbus_mode)
        else $error("mode bits wrong");
    addr_high_a: assert property (live_s |-> config_out.slave_addr[6:3] == 4'h1)
        else $error("address bit3 wrong");
    addr_low_a: assert property (live_s |->
        config_out.slave_addr[2:1] == (config_out.smbus_mode ?
        {config_out.ganged, !config_out.switching_enabled} : 2'h0))
        else $error("address bits 2:1 wrong");
    status_follow_a: assert property (live_s ##1 live_s |->
        strap_pin_out == $past(link_status)) else $error("status pins wrong");
    cfg_hold_a: assert property (live_s ##1 live_s |-> $stable(config_out))
        else $error("config changed");
    serial_route_a: assert property (live_s ##1 live_s |->
        scl_oe == $past(engine_serial.scl_oe[config_out.smbus_mode])) else $error("route");
    port_oc_a: assert property (live_s [*4] ##0
        (!config_out.ganged && config_out.switching_enabled)
        |-> port_overcurrent[0] == !$past(overcurrent_port1_n, 3)) else $error("port oc");
    hub_oc_a: assert property (live_s [*4] ##0
        (config_out.ganged && config_out.switching_enabled)
        |-> hub_overcurrent == !($past(overcurrent_port1_n, 3) && $past(overcurrent_port2_n, 3)))
        else $error("hub oc");
endmodule // strap_cfg_chk
bind reset_strap_config_status strap_cfg_chk u_strap_cfg_chk (.core_clk, .reset_n,
    .strap_pin_out, .strap_pin_oe, .link_status, .overcurrent_port1_n, .overcurrent_port2_n,
    .port_overcurrent, .hub_overcurrent, .config_out, .engine_serial, .scl_oe);

// >>> tb/tb_top.sv
// Self-checking bench for the strap block
`timescale 1ns/1ps
module tb_top;
    import strap_cfg_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    straps_t board_cfg = 5'h00;
    straps_t strap_in;
    logic [3:0] strap_pin_out, strap_pin_oe;
    link_status_t link_status = 4'h0;
    logic [1:0] port_power_request = 2'h0;
    logic [1:0] port_power_control_out, port_overcurrent;
    logic overcurrent_port1_n = 1'b1;
    logic overcurrent_port2_n = 1'b1;
    logic hub_overcurrent, scl_out, scl_oe, sda_out, sda_oe;
    config_t config_out;
    serial_route_t engine_serial = 8'h96;
    int n_fail = 0;
    int tests_run = 0;
    always #12.5 core_clk = ~core_clk;
    reset_strap_config_status u_reset_strap_config_status (.core_clk, .reset_n, .strap_in,
        .strap_pin_out, .strap_pin_oe, .link_status, .port_power_request, .port_power_control_out,
        .overcurrent_port1_n, .overcurrent_port2_n, .port_overcurrent, .hub_overcurrent,
        .config_out, .engine_serial, .scl_out, .scl_oe, .sda_out, .sda_oe);
    strap_board u_strap_board (.board_cfg, .drv(strap_pin_out), .drv_oe(strap_pin_oe),
        .level(strap_in));
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Reset with given straps, then check config, routing, status, power, overcurrent
    task automatic run_case(input straps_t s);
        logic sw;
        logic [11:0] cfg;
        int k;
        board_cfg = s;
        reset_n = 1'b0;
        tick(16);
        reset_n = 1'b1;
        k = 0;
        while (strap_pin_oe !== 4'hF && k < 20)
        begin
            tick(1);
            k++;
        end
        if (k == 20)
        begin
            n_fail++;
            final_report();
        end
        sw = !s[1];
        cfg = {s[4], !s[4], s[2], sw, s[0], 4'h1, !s[4] & s[2], !s[4] & s[1], 1'b0};
        check(config_out, cfg);
        check({scl_out, scl_oe, sda_out, sda_oe}, s[4] ? 4'h9 : 4'h6);
        link_status = 4'hA;
        tick(2);
        check(strap_pin_out, 4'hA);
        board_cfg = ~s;
        link_status = 4'h5;
        tick(2);
        check({strap_pin_out, config_out}, {4'h5, cfg});
        port_power_request = 2'h1;
        tick(2);
        check(port_power_control_out, (sw ? (s[2] ? 2'h3 : 2'h1) : 2'h0) ^ {2{s[3]}});
        overcurrent_port2_n = 1'b0;
        tick(4);
        if (sw)
            check({port_overcurrent, hub_overcurrent}, s[2] ? 3'h1 : 3'h4);
        overcurrent_port2_n = 1'b1;
        overcurrent_port1_n = 1'b0;
        tick(4);
        check(port_power_control_out, {2{s[3]}});
        if (sw)
            check({port_overcurrent, hub_overcurrent}, s[2] ? 3'h1 : 3'h2);
        overcurrent_port1_n = 1'b1;
        port_power_request = 2'h0;
    endtask
    initial
    begin
        run_case(5'h14);
        run_case(5'h0A);
        run_case(5'h04);
        run_case(5'h19);
        final_report();
    end
endmodule // tb_top
